// ===== aic_pkg.sv
// package: constants, register map and types of the accelerometer interrupt control block
package aic_pkg;

    // ****************************************************************
    // register word indices and byte addresses
    // ****************************************************************
    localparam logic [7:0] AIC_IDX_CTRL   = 8'h2C;
    localparam logic [7:0] AIC_IDX_ENABLE = 8'h2D;
    localparam logic [7:0] AIC_IDX_ROUTE  = 8'h2E;
    localparam logic [7:0] AIC_IDX_STATUS = 8'h2F;
    localparam logic [7:0] AIC_IDX_MASK   = 8'h30;
    localparam logic [7:0] AIC_IDX_MODE   = 8'h31;
    localparam logic [9:0] AIC_ADDR_CTRL   = {AIC_IDX_CTRL, 2'b00};
    localparam logic [9:0] AIC_ADDR_ENABLE = {AIC_IDX_ENABLE, 2'b00};
    localparam logic [9:0] AIC_ADDR_ROUTE  = {AIC_IDX_ROUTE, 2'b00};
    localparam logic [9:0] AIC_ADDR_STATUS = {AIC_IDX_STATUS, 2'b00};
    localparam logic [9:0] AIC_ADDR_MASK   = {AIC_IDX_MASK, 2'b00};
    localparam logic [9:0] AIC_ADDR_MODE   = {AIC_IDX_MODE, 2'b00};

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int AIC_CTRL_FIFO_GATE  = 7;
    localparam int AIC_CTRL_WAKE_TRANS = 6;
    localparam int AIC_CTRL_WAKE_ORIENT = 5;
    localparam int AIC_CTRL_WAKE_PULSE = 4;
    localparam int AIC_CTRL_WAKE_FFMT  = 3;
    localparam int AIC_CTRL_WAKE_VECM  = 2;
    localparam int AIC_CTRL_POLARITY   = 1;
    localparam int AIC_CTRL_DRIVE_MODE = 0;
    localparam int AIC_SRC_SLEEP  = 7;
    localparam int AIC_SRC_FIFO   = 6;
    localparam int AIC_SRC_TRANS  = 5;
    localparam int AIC_SRC_ORIENT = 4;
    localparam int AIC_SRC_PULSE  = 3;
    localparam int AIC_SRC_FFMT   = 2;
    localparam int AIC_SRC_VECM   = 1;
    localparam int AIC_SRC_DRDY   = 0;
    // status register bits
    localparam int AIC_ST_GATE_ERR = 0;
    localparam int AIC_ST_FLUSH    = 1;
    localparam int AIC_ST_PIN_A    = 2;
    localparam int AIC_ST_PIN_B    = 3;
    // mode register bits
    localparam int AIC_MODE_SLEEP    = 0;
    localparam int AIC_MODE_GATE_ERR = 1;
    localparam int AIC_MODE_BLOCKED  = 2;

    // ****************************************************************
    // reset values and bus codes
    // ****************************************************************
    localparam logic [7:0] AIC_CTRL_RST   = 8'h00;
    localparam logic [7:0] AIC_ENABLE_RST = 8'h00;
    localparam logic [7:0] AIC_ROUTE_RST  = 8'h00;
    localparam logic [3:0] AIC_STATUS_RST = 4'h0;
    localparam logic [3:0] AIC_MASK_RST   = 4'h0;
    localparam logic [1:0] AIC_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] AIC_HSIZE_WORD    = 3'h2;

    typedef enum logic [0:0] {
        AIC_PH_IDLE = 1'b0,
        AIC_PH_DATA = 1'b1
    } aic_phase_t;

    typedef struct packed {
        logic [9:0] addr;
        logic       write;
        logic       valid;
    } aic_req_t;

    typedef struct packed {
        logic       pin_a_out;
        logic       pin_a_oe;
        logic       pin_b_out;
        logic       pin_b_oe;
    } aic_pins_t;

    typedef struct packed {
        aic_phase_t phase;
        aic_req_t   req;
        logic [7:0] ctrl;
        logic [7:0] enable;
        logic [7:0] route;
        logic [3:0] status;
        logic [3:0] mask;
        logic [31:0] rdata;
        logic       irq;
        aic_pins_t  pins;
        logic       gate_err;
        logic       blocked;
        logic       flush;
        logic       sleep_prev;
        logic [2:0] rate_prev;
        logic       mode_s1;
        logic       mode_s2;
        logic [7:0] det_en;
        logic       accept;
    } aic_state_t;

endpackage : aic_pkg

// ===== aic_ctrl.sv
// module: interrupt control, FIFO gate and pin drive of the accelerometer, AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module aic_ctrl
    import aic_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        sleep_mode_in,
    input  wire logic [2:0]  output_sample_rate,
    input  wire logic [7:0]  event_flags,
    input  wire logic        sample_strobe,
    input  wire logic        fifo_empty,
    output logic             fifo_flush,
    output logic             fifo_accept,
    output logic [7:0]       detector_enable,
    output logic             irq_pin_a_out,
    output logic             irq_pin_a_oe,
    output logic             irq_pin_b_out,
    output logic             irq_pin_b_oe,
    output logic             irq
);

    aic_state_t s_q;
    aic_state_t s_d;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // both pins: level of the ORed sources, polarity and drive mode applied
    function automatic aic_pins_t pin_drive(input logic act_a, input logic act_b,
                                            input logic pol, input logic od);
        aic_pins_t p;
        p.pin_a_out = pol ? act_a : ~act_a;
        p.pin_b_out = pol ? act_b : ~act_b;
        p.pin_a_oe  = od ? act_a : 1'b1;
        p.pin_b_oe  = od ? act_b : 1'b1;
        if (od) begin
            p.pin_a_out = pol;
            p.pin_b_out = pol;
        end
        return p;
    endfunction : pin_drive

    function automatic logic [31:0] read_mux(input aic_state_t s, input logic [9:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            AIC_ADDR_CTRL:   r[7:0] = s.ctrl;
            AIC_ADDR_ENABLE: r[7:0] = s.enable;
            AIC_ADDR_ROUTE:  r[7:0] = s.route;
            AIC_ADDR_STATUS: r[3:0] = s.status;
            AIC_ADDR_MASK:   r[3:0] = s.mask;
            AIC_ADDR_MODE: begin
                r[AIC_MODE_SLEEP]    = s.mode_s2;
                r[AIC_MODE_GATE_ERR] = s.gate_err;
                r[AIC_MODE_BLOCKED]  = s.blocked;
            end
            default:         r = 32'h0000_0000;
        endcase
        return r;
    endfunction : read_mux

    // ****************************************************************
    // next state
    // ****************************************************************
    logic       take;
    logic       mode_change;
    logic       rate_change;
    logic       flush_now;
    logic       gate;
    logic [7:0] routed;
    logic       act_a;
    logic       act_b;
    logic [3:0] events;
    logic [3:0] rd_clear;

    always_comb begin
        s_d = s_q;
        take = hsel && hready && (htrans == AIC_HTRANS_NONSEQ);
        gate = s_q.ctrl[AIC_CTRL_FIFO_GATE];
        rd_clear = 4'h0;

        // bus: write data and read data both land in the data phase
        s_d.phase = take ? AIC_PH_DATA : AIC_PH_IDLE;
        s_d.req.addr  = haddr[9:0];
        s_d.req.write = hwrite;
        s_d.req.valid = take && (haddr[31:10] == 22'h00_0000) && (hsize == AIC_HSIZE_WORD);
        if (s_q.phase == AIC_PH_DATA && s_q.req.valid && s_q.req.write) begin
            unique case (s_q.req.addr)
                AIC_ADDR_CTRL:   s_d.ctrl   = hwdata[7:0];
                AIC_ADDR_ENABLE: s_d.enable = hwdata[7:0];
                AIC_ADDR_ROUTE:  s_d.route  = hwdata[7:0];
                AIC_ADDR_MASK:   s_d.mask   = hwdata[3:0];
                default:         s_d.ctrl   = s_q.ctrl;
            endcase
        end
        // read data is prepared at the address phase so it stands in the data phase
        s_d.rdata = 32'h0000_0000;
        if (take && !hwrite) begin
            s_d.rdata = read_mux(s_q, haddr[9:0]);
            if (haddr[9:0] == AIC_ADDR_STATUS) begin
                rd_clear = 4'hF;
            end
        end

        // mode input from outside passes two flip-flops
        s_d.mode_s1 = sleep_mode_in;
        s_d.mode_s2 = s_q.mode_s1;
        s_d.sleep_prev = s_q.mode_s2;
        s_d.rate_prev  = output_sample_rate;
        mode_change = s_q.mode_s2 != s_q.sleep_prev;
        rate_change = output_sample_rate != s_q.rate_prev;

        // fifo gate
        flush_now = rate_change;
        if (mode_change && !gate) begin
            flush_now = 1'b1;
        end
        if (mode_change && gate) begin
            s_d.blocked = 1'b1;
        end
        if (sample_strobe && s_q.blocked && !fifo_empty) begin
            s_d.gate_err = 1'b1;
        end
        if (fifo_empty && !(mode_change && gate)) begin
            s_d.blocked  = 1'b0;
            s_d.gate_err = 1'b0;
        end
        if (flush_now) begin
            s_d.blocked  = 1'b0;
        end
        s_d.flush  = flush_now;
        s_d.accept = sample_strobe && !s_d.blocked;

        // sleep-time detector enables; awake everything runs
        s_d.det_en = 8'hFF;
        if (s_q.mode_s2) begin
            s_d.det_en[AIC_SRC_TRANS]  = s_q.ctrl[AIC_CTRL_WAKE_TRANS];
            s_d.det_en[AIC_SRC_ORIENT] = s_q.ctrl[AIC_CTRL_WAKE_ORIENT];
            s_d.det_en[AIC_SRC_PULSE]  = s_q.ctrl[AIC_CTRL_WAKE_PULSE];
            s_d.det_en[AIC_SRC_FFMT]   = s_q.ctrl[AIC_CTRL_WAKE_FFMT];
            s_d.det_en[AIC_SRC_VECM]   = s_q.ctrl[AIC_CTRL_WAKE_VECM];
        end

        // routing to the two pins
        routed = event_flags & s_q.enable;
        act_a  = |(routed & s_q.route);
        act_b  = |(routed & ~s_q.route);
        s_d.pins = pin_drive(act_a, act_b, s_q.ctrl[AIC_CTRL_POLARITY],
                             s_q.ctrl[AIC_CTRL_DRIVE_MODE]);

        // sticky status: a new event beats the clearing read
        events = 4'h0;
        events[AIC_ST_GATE_ERR] = s_d.gate_err && !s_q.gate_err;
        events[AIC_ST_FLUSH]    = flush_now;
        events[AIC_ST_PIN_A]    = act_a;
        events[AIC_ST_PIN_B]    = act_b;
        s_d.status = (s_q.status & ~rd_clear) | events;
        s_d.irq    = |(s_d.status & s_q.mask);
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '{phase: AIC_PH_IDLE, req: '0, ctrl: AIC_CTRL_RST,
                     enable: AIC_ENABLE_RST, route: AIC_ROUTE_RST,
                     status: AIC_STATUS_RST, mask: AIC_MASK_RST, rdata: 32'h0000_0000,
                     irq: 1'b0, pins: '{pin_a_out: 1'b1, pin_a_oe: 1'b1,
                                        pin_b_out: 1'b1, pin_b_oe: 1'b1},
                     gate_err: 1'b0, blocked: 1'b0, flush: 1'b0, sleep_prev: 1'b0,
                     rate_prev: 3'h0, mode_s1: 1'b0, mode_s2: 1'b0,
                     det_en: 8'hFF, accept: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs straight from flip-flops, hreadyout and hresp tied constant
    // ****************************************************************
    assign hrdata          = s_q.rdata;
    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign fifo_flush      = s_q.flush;
    assign fifo_accept     = s_q.accept;
    assign detector_enable = s_q.det_en;
    assign irq_pin_a_out   = s_q.pins.pin_a_out;
    assign irq_pin_a_oe    = s_q.pins.pin_a_oe;
    assign irq_pin_b_out   = s_q.pins.pin_b_out;
    assign irq_pin_b_oe    = s_q.pins.pin_b_oe;
    assign irq             = s_q.irq;

endmodule : aic_ctrl

// ===== aic_ctrl_checker.sv
// checker: port-level assertions of the interrupt control block
`timescale 1ns/100ps
module aic_ctrl_checker
    import aic_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        sleep_mode_in,
    input wire logic [2:0]  output_sample_rate,
    input wire logic        sample_strobe,
    input wire logic        fifo_flush,
    input wire logic        fifo_accept,
    input wire logic [7:0]  detector_enable,
    input wire logic        irq_pin_a_out,
    input wire logic        irq_pin_a_oe,
    input wire logic        irq_pin_b_out,
    input wire logic        irq_pin_b_oe
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_rate_flush; $changed(output_sample_rate) |=> fifo_flush; endproperty
    a_rate_flush: assert property (p_rate_flush) else $error("no flush after rate change");
    property p_accept; fifo_accept |-> $past(sample_strobe); endproperty
    a_accept: assert property (p_accept) else $error("accept without a sample");
    // sync stages plus register: five quiet cycles is ample
    property p_awake; !sleep_mode_in [*5] |=> detector_enable == 8'hFF; endproperty
    a_awake: assert property (p_awake) else $error("detector off while awake");
    property p_fixed; detector_enable[7] && detector_enable[6] && detector_enable[0]; endproperty
    a_fixed: assert property (p_fixed) else $error("detector without sleep bit is off");
    property p_rd_idle;
        !(hsel && hready && htrans == AIC_HTRANS_NONSEQ && !hwrite) |=> hrdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
    // a released pin means open-drain: both pins then hold the polarity level
    property p_od_a; !irq_pin_a_oe |-> irq_pin_a_out == irq_pin_b_out; endproperty
    a_od_a: assert property (p_od_a) else $error("pin a level differs in open drain");
    property p_od_b; !irq_pin_b_oe |-> irq_pin_b_out == irq_pin_a_out; endproperty
    a_od_b: assert property (p_od_b) else $error("pin b level differs in open drain");
    property p_bus_ok; hreadyout && !hresp; endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus wait or error response");
    c_flush: cover property (fifo_flush);
    c_release: cover property (!irq_pin_a_oe);
    c_accept: cover property (fifo_accept);
endmodule : aic_ctrl_checker

// ===== aic_pin_pullup.sv
// far-side model: interrupt lines with external pull-ups as the host sees them
`timescale 1ns/100ps
module aic_pin_pullup (
    input  wire logic irq_pin_a_out,
    input  wire logic irq_pin_a_oe,
    input  wire logic irq_pin_b_out,
    input  wire logic irq_pin_b_oe,
    output logic      a_lvl,
    output logic      b_lvl
);
    // an undriven line floats up, never keeps its last level
    assign a_lvl = irq_pin_a_oe ? irq_pin_a_out : 1'b1;
    assign b_lvl = irq_pin_b_oe ? irq_pin_b_out : 1'b1;
endmodule : aic_pin_pullup

// ===== test_accel_interrupt_control.sv
// testbench: registers, pin routing, FIFO gate and interrupt scenarios
`timescale 1ns/100ps
module test_accel_interrupt_control;
    import aic_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_due = 1'b0;
    logic        sleep_mode_in = 1'b0, sample_strobe = 1'b0, fifo_empty = 1'b0, pa, pb;
    logic        hreadyout, hresp, fifo_flush, fifo_accept, irq, a_lvl, b_lvl, hit;
    logic        irq_pin_a_out, irq_pin_a_oe, irq_pin_b_out, irq_pin_b_oe;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, lfsr = 32'h93DD;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = AIC_HSIZE_WORD, output_sample_rate = 3'h0;
    logic [7:0]  event_flags = 8'h00, detector_enable, en, rt;
    logic [32:0] q, exp_q[$];
    wire logic   hready;
    int          fails = 0, check_count = 0;
    assign hready = hreadyout;
    aic_ctrl DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .sleep_mode_in, .output_sample_rate, .event_flags,
        .sample_strobe, .fifo_empty, .fifo_flush, .fifo_accept, .detector_enable,
        .irq_pin_a_out, .irq_pin_a_oe, .irq_pin_b_out, .irq_pin_b_oe, .irq);
    aic_pin_pullup u_pins (.irq_pin_a_out, .irq_pin_a_oe, .irq_pin_b_out, .irq_pin_b_oe,
        .a_lvl, .b_lvl);
    always #10 hclk = ~hclk;
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic results();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    function automatic logic lvl(input logic act, input logic pol, input logic od);
        return act ? pol : (od ? 1'b1 : ~pol);
    endfunction : lvl
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                fails++;
                results();
            end
            @(posedge hclk);
        end
    endtask : wait_ready
    // a read notes its expectation; the monitor compares in the data phase
    task automatic bus(input logic [31:0] a, input logic is_wr, input logic [31:0] d,
                       input logic c);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= is_wr;
        htrans <= AIC_HTRANS_NONSEQ;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        if (!is_wr) exp_q.push_back({c, d});
        rd_due <= !is_wr;
        wait_ready();
        rd_due <= 1'b0;
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, 1'b0);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        bus(a, 1'b0, e, 1'b1);
    endtask : rd
    always @(posedge hclk) begin
        if (rd_due && exp_q.size() > 0) begin
            q = exp_q.pop_front();
            if (q[32]) chk(hrdata, q[31:0]);
        end
    end
    initial begin
        #200000;
        fails++;
        results();
    end
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int k = 0; k < 5; k++) rd(32'(AIC_ADDR_CTRL) + 32'(k * 4), 32'h0);
        chk(32'({a_lvl, b_lvl, irq_pin_a_oe, irq_pin_b_oe}), 32'hF);
        wr(32'h100, rnd());
        rd(32'h100, 32'h0);
        for (int m = 0; m < 4; m++) begin
            wr(32'(AIC_ADDR_CTRL), 32'(m));
            for (int i = 0; i < 8; i++) begin
                en = 8'(rnd());
                rt = 8'(rnd());
                wr(32'(AIC_ADDR_ENABLE), {24'h0, en});
                wr(32'(AIC_ADDR_ROUTE), {24'h0, rt});
                rd(32'(AIC_ADDR_ENABLE), {24'h0, en});
                rd(32'(AIC_ADDR_ROUTE), {24'h0, rt});
                event_flags <= 8'(rnd()) | (8'h01 << i);
                @(posedge hclk);
                #1;
                pa = |(event_flags & en & rt);
                pb = |(event_flags & en & ~rt);
                chk(32'({a_lvl, b_lvl}), 32'({lvl(pa, m[1], m[0]), lvl(pb, m[1], m[0])}));
                chk(32'({irq_pin_a_oe, irq_pin_b_oe}), 32'({!m[0] || pa, !m[0] || pb}));
                @(posedge hclk);
            end
        end
        // a byte-sized write is refused and leaves the register alone
        hsize <= 3'h0;
        wr(32'(AIC_ADDR_ENABLE), {24'h0, ~en});
        hsize <= AIC_HSIZE_WORD;
        rd(32'(AIC_ADDR_ENABLE), {24'h0, en});
        event_flags <= 8'h00;
        bus(32'(AIC_ADDR_STATUS), 1'b0, 32'h0, 1'b0);
        output_sample_rate <= 3'h5;
        @(posedge hclk);
        #1 chk(32'(fifo_flush), 32'h1);
        @(posedge hclk);
        wr(32'(AIC_ADDR_CTRL), 32'hD4);
        sleep_mode_in <= 1'b1;
        repeat (6) begin
            @(posedge hclk);
            #1 chk(32'(fifo_flush), 32'h0);
        end
        chk(32'(detector_enable), 32'hEB);
        @(posedge hclk);
        sample_strobe <= 1'b1;
        @(posedge hclk);
        sample_strobe <= 1'b0;
        #1 chk(32'(fifo_accept), 32'h0);
        @(posedge hclk);
        rd(32'(AIC_ADDR_MODE), 32'h7);
        fifo_empty <= 1'b1;
        repeat (2) @(posedge hclk);
        rd(32'(AIC_ADDR_MODE), 32'h1);
        wr(32'(AIC_ADDR_CTRL), 32'h28);
        repeat (2) @(posedge hclk);
        #1 chk(32'(detector_enable), 32'hD5);
        @(posedge hclk);
        sleep_mode_in <= 1'b0;
        hit = 1'b0;
        repeat (8) begin
            @(posedge hclk);
            hit = hit | fifo_flush;
        end
        chk(32'(hit), 32'h1);
        sample_strobe <= 1'b1;
        @(posedge hclk);
        sample_strobe <= 1'b0;
        #1 chk(32'({fifo_accept, detector_enable}), 32'h1FF);
        @(posedge hclk);
        rd(32'(AIC_ADDR_STATUS), 32'h3);
        for (int k = 1; k >= 0; k--) begin
            wr(32'(AIC_ADDR_MASK), 32'(k * 2));
            output_sample_rate <= output_sample_rate + 3'h1;
            repeat (4) @(posedge hclk);
            #1 chk(32'(irq), 32'(k));
            @(posedge hclk);
            rd(32'(AIC_ADDR_STATUS), 32'h2);
        end
        rd(32'(AIC_ADDR_STATUS), 32'h0);
        results();
    end
endmodule : test_accel_interrupt_control
bind aic_ctrl aic_ctrl_checker u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .sleep_mode_in, .output_sample_rate, .sample_strobe, .fifo_flush,
    .fifo_accept, .detector_enable, .irq_pin_a_out, .irq_pin_a_oe, .irq_pin_b_out, .irq_pin_b_oe);
